// ### hw/pdc_map.svh
// Register map, field positions, reset values and timing counts of the power-down controller
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH
`define PDC_SPC_OFFSET 32'h0000ffc4
`define PDC_STAT_OFFSET 32'h0000ffc8
`define PDC_SPC_RESET 8'h09
`define PDC_BIT_SOFT_STANDBY_SELECT 7
`define PDC_BIT_STS_HI 6
`define PDC_BIT_STS_LO 4
`define PDC_BIT_NMI_EDGE_SELECT 2
`define PDC_BIT_DUAL_PORT_MEM_ENABLE 1
`define PDC_BIT_ONCHIP_RAM_ENABLE 0
`define PDC_SETTLE_BASE 32'd8192
`define PDC_SETTLE_MAX 32'd131072
`endif

// ### hw/pdc_pkg.sv
// Types of the power-down controller
package pdc_pkg;
  typedef enum logic [2:0]
  {
    PDC_RUN = 3'b000,
    PDC_SLEEP = 3'b001,
    PDC_SSTBY = 3'b010,
    PDC_SETTLE = 3'b011,
    PDC_RES_WAIT = 3'b100,
    PDC_HSTBY = 3'b101
  } pdc_state_type;
endpackage

// ### hw/pdc_power_down_controller.sv
// Power-down controller: sleep, software standby, hardware standby and settling wait
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pdc_map.svh"
module pdc_power_down_controller
  import pdc_pkg::*;
#(
  parameter int unsigned SETTLE_BASE = `PDC_SETTLE_BASE
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_sleep_req,
  input wire logic i_cpu_imask,
  input wire logic i_periph_irq,
  input wire logic i_res_pin_n,
  input wire logic i_hard_standby_pin_n,
  input wire logic i_nmi_pin_n,
  input wire logic [2:0] i_irq_pin_n,
  output logic o_osc_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_periph_reset,
  output logic o_cpu_reset,
  output logic o_wake_irq,
  output logic o_nmi_edge,
  output logic o_hard_standby,
  output logic o_dual_port_mem_enable,
  output logic o_onchip_ram_enable
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pin_meta_q, pin_sync_q;
  logic nmi_prev_q;
  logic [2:0] irq_prev_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_meta_q <= 6'h3f;
      pin_sync_q <= 6'h3f;
    end
    else
    begin
      pin_meta_q <= {i_irq_pin_n, i_nmi_pin_n, i_hard_standby_pin_n, i_res_pin_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic res_n_s, hstby_n_s, nmi_n_s;
  logic [2:0] irq_n_s;
  assign {irq_n_s, nmi_n_s, hstby_n_s, res_n_s} = pin_sync_q;

  // ****************************************
  // Control register
  // ****************************************
  logic soft_standby_select_q, nmi_edge_select_q, dual_port_mem_enable_q, onchip_ram_enable_q;
  logic [2:0] sts_q;
  pdc_state_type state_q, state_d;
  logic [17:0] settle_cnt_q;

  // Settling length in states for a given field code
  function automatic logic [17:0] settle_len(input logic [2:0] code);
    logic [17:0] base;
    base = 18'(SETTLE_BASE);
    if (code[2])
      settle_len = base << 4;
    else
      settle_len = base << code[1:0];
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held_q, w_held_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, wr_spc;
  assign o_s_axi_awready = !aw_held_q && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held_q && !o_s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q && !o_s_axi_bvalid;
  assign wr_spc = do_write && awaddr_q == `PDC_SPC_OFFSET && wstrb_q[0];

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (awaddr_q == `PDC_SPC_OFFSET || awaddr_q == `PDC_STAT_OFFSET) ? 2'h0
          : 2'h2;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= 2'h0;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= 2'h0;
      if (i_s_axi_araddr == `PDC_SPC_OFFSET)
        o_s_axi_rdata <= {24'h0, soft_standby_select_q, sts_q, 1'b1, nmi_edge_select_q, dual_port_mem_enable_q, onchip_ram_enable_q};
      else if (i_s_axi_araddr == `PDC_STAT_OFFSET)
        o_s_axi_rdata <= {11'h0, settle_cnt_q, state_q};
      else
      begin
        o_s_axi_rdata <= 32'h0;
        o_s_axi_rresp <= 2'h2;
      end
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  // Register fields; reset pin release from standby clears select
  logic clear_soft_standby_select;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      soft_standby_select_q <= 1'(`PDC_SPC_RESET >> `PDC_BIT_SOFT_STANDBY_SELECT);
      sts_q <= 3'h0;
      nmi_edge_select_q <= 1'b0;
      dual_port_mem_enable_q <= 1'b0;
      onchip_ram_enable_q <= 1'b1;
    end
    else if (clear_soft_standby_select || state_q == PDC_HSTBY)
    begin
      soft_standby_select_q <= 1'b0;
      sts_q <= 3'h0;
      nmi_edge_select_q <= 1'b0;
      dual_port_mem_enable_q <= 1'b0;
      onchip_ram_enable_q <= 1'b1;
    end
    else if (wr_spc)
    begin
      soft_standby_select_q <= wdata_q[`PDC_BIT_SOFT_STANDBY_SELECT];
      sts_q <= wdata_q[`PDC_BIT_STS_HI:`PDC_BIT_STS_LO];
      nmi_edge_select_q <= wdata_q[`PDC_BIT_NMI_EDGE_SELECT];
      dual_port_mem_enable_q <= wdata_q[`PDC_BIT_DUAL_PORT_MEM_ENABLE];
      onchip_ram_enable_q <= wdata_q[`PDC_BIT_ONCHIP_RAM_ENABLE];
    end
  end

  // ****************************************
  // Wake sources
  // ****************************************
  logic nmi_evt;
  logic [2:0] irq_lvl;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      nmi_prev_q <= 1'b1;
      irq_prev_q <= 3'h7;
    end
    else
    begin
      nmi_prev_q <= nmi_n_s;
      irq_prev_q <= irq_n_s;
    end
  end

  // Edge chosen by the edge select bit
  assign nmi_evt = nmi_edge_select_q ? (nmi_n_s && !nmi_prev_q) : (!nmi_n_s && nmi_prev_q);
  assign irq_lvl = ~irq_n_s;

  logic sleep_wake, sstby_wake;
  // Peripheral request arrives already gated by its own enable bit
  assign sleep_wake = nmi_evt || (!i_cpu_imask && (i_periph_irq || (|irq_lvl)));
  // Only NMI and IRQ0-2 may wake from software standby; IRQ3-7 are off by software
  assign sstby_wake = nmi_evt || (!i_cpu_imask && (|irq_lvl));

  // ****************************************
  // Power-down state machine
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    clear_soft_standby_select = 1'b0;
    case (state_q)
      PDC_RUN:
        if (i_sleep_req)
          state_d = soft_standby_select_q ? PDC_SSTBY : PDC_SLEEP;
      PDC_SLEEP:
        if (!res_n_s)
          state_d = PDC_RUN;
        else if (sleep_wake)
          state_d = PDC_RUN;
      PDC_SSTBY:
        if (!res_n_s)
          state_d = PDC_RES_WAIT;
        else if (sstby_wake)
          state_d = PDC_SETTLE;
      PDC_SETTLE:
        if (settle_cnt_q >= settle_len(sts_q) - 18'h1)
          state_d = PDC_RUN;
      PDC_RES_WAIT:
        if (res_n_s)
        begin
          state_d = PDC_RUN;
          clear_soft_standby_select = 1'b1;
        end
      PDC_HSTBY:
        if (hstby_n_s)
          state_d = PDC_RES_WAIT;
      default:
        state_d = PDC_RUN;
    endcase
    if (!hstby_n_s)
      state_d = PDC_HSTBY;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_q <= PDC_RUN;
    else
      state_q <= state_d;
  end

  // Settling counter runs on the free oscillator clock, one step a state
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      settle_cnt_q <= 18'h0;
    else if (state_q == PDC_SETTLE)
      settle_cnt_q <= settle_cnt_q + 18'h1;
    else
      settle_cnt_q <= 18'h0;
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic wake_irq_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      wake_irq_q <= 1'b0;
    else
      wake_irq_q <= (state_q == PDC_SLEEP && state_d == PDC_RUN && res_n_s)
        || (state_q == PDC_SETTLE && state_d == PDC_RUN);
  end

  assign o_wake_irq = wake_irq_q;
  assign o_osc_en = !(state_q == PDC_SSTBY || state_q == PDC_HSTBY);
  assign o_cpu_clk_en = state_q == PDC_RUN;
  // Peripherals run in sleep but are frozen in both standby modes
  assign o_periph_clk_en = state_q == PDC_RUN || state_q == PDC_SLEEP;
  assign o_periph_reset = state_q == PDC_SSTBY || state_q == PDC_SETTLE
    || state_q == PDC_HSTBY || state_q == PDC_RES_WAIT;
  // Reset held in the CPU until the pin rises; sleep exit by pin also resets
  assign o_cpu_reset = state_q == PDC_RES_WAIT || state_q == PDC_HSTBY || !res_n_s;
  assign o_hard_standby = state_q == PDC_HSTBY;
  assign o_nmi_edge = nmi_edge_select_q;
  assign o_dual_port_mem_enable = dual_port_mem_enable_q;
  assign o_onchip_ram_enable = onchip_ram_enable_q;

endmodule // pdc_power_down_controller
`default_nettype wire

// ### testbench/pdc_monitor.sv
// Checker of the power-down controller outputs
`timescale 1ns/100ps
`default_nettype none
module pdc_monitor
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_sleep_req,
  input wire logic i_res_pin_n,
  input wire logic i_hard_standby_pin_n,
  input wire logic o_osc_en,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_periph_reset,
  input wire logic o_cpu_reset,
  input wire logic o_wake_irq,
  input wire logic o_hard_standby
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sleep_stop_a: assert property (i_sleep_req && o_cpu_clk_en |=> !o_cpu_clk_en)
    else $error("cpu clock kept after sleep");
  sleep_run_a: assert property
    (o_periph_clk_en && !o_cpu_clk_en |-> o_osc_en && !o_periph_reset)
    else $error("peripherals stopped in sleep");
  standby_gate_a: assert property (!o_osc_en |-> !o_periph_clk_en && o_periph_reset)
    else $error("clocks run in standby");
  settle_gate_a: assert property
    (o_osc_en && o_periph_reset && !o_cpu_reset |-> !o_cpu_clk_en && !o_periph_clk_en)
    else $error("clocks run while settling");
  hard_entry_a: assert property (!i_hard_standby_pin_n [*4] |-> o_hard_standby)
    else $error("standby pin ignored");
  hard_gate_a: assert property (o_hard_standby |-> !o_osc_en && o_cpu_reset)
    else $error("hardware standby not halted");
  wake_rise_a: assert property
    ($rose(o_wake_irq) |-> o_cpu_clk_en && !$past(o_cpu_clk_en))
    else $error("wake pulse without wake");
  wake_once_a: assert property (o_wake_irq |=> !o_wake_irq)
    else $error("wake pulse too long");
  reset_pin_a: assert property (!i_res_pin_n [*3] |=> o_cpu_reset)
    else $error("reset pin ignored");
endmodule // pdc_monitor
bind pdc_power_down_controller pdc_monitor pdc_monitor_inst(.i_sys_clk, .i_reset_n, .i_sleep_req,
  .i_res_pin_n, .i_hard_standby_pin_n, .o_osc_en, .o_cpu_clk_en, .o_periph_clk_en,
  .o_periph_reset, .o_cpu_reset, .o_wake_irq, .o_hard_standby);
`default_nettype wire

// ### testbench/pdc_cpu_model.sv
// CPU core model that executes the sleep instruction
`timescale 1ns/100ps
`default_nettype none
module pdc_cpu_model
(
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic i_cpu_clk_en,
  output logic o_sleep_req
);
  // A halted CPU cannot execute sleep; IRQ3-7 are never enabled here
  always_ff @(posedge i_sys_clk)
    o_sleep_req <= i_go && i_cpu_clk_en && !o_sleep_req;
endmodule // pdc_cpu_model
`default_nettype wire

// ### testbench/pdc_power_down_controller_tb.sv
// Self-checking bench of the power-down controller
`timescale 1ns/100ps
`default_nettype none
`include "pdc_map.svh"
module pdc_power_down_controller_tb;
  localparam logic [31:0] SPC = `PDC_SPC_OFFSET;
  logic i_sys_clk, i_reset_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic i_s_axi_rready, i_cpu_imask, i_periph_irq, i_res_pin_n, i_hard_standby_pin_n;
  logic i_nmi_pin_n, go, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_osc_en, o_cpu_clk_en, o_periph_clk_en, o_periph_reset, o_cpu_reset;
  logic o_wake_irq, o_nmi_edge, o_hard_standby, o_dual_port_mem_enable, o_onchip_ram_enable;
  logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata, v;
  logic [3:0] i_s_axi_wstrb;
  logic [2:0] i_irq_pin_n;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire logic i_sleep_req;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int wq[$];
  int n_errors = 0, compares = 0, cnt = 0, seed = 32'h32c4da32;
  pdc_power_down_controller #(.SETTLE_BASE(4)) pdc_power_down_controller_inst(.i_sys_clk,
    .i_reset_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
    .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
    .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_sleep_req, .i_cpu_imask,
    .i_periph_irq, .i_res_pin_n, .i_hard_standby_pin_n, .i_nmi_pin_n, .i_irq_pin_n,
    .o_osc_en, .o_cpu_clk_en, .o_periph_clk_en, .o_periph_reset, .o_cpu_reset, .o_wake_irq,
    .o_nmi_edge, .o_hard_standby, .o_dual_port_mem_enable, .o_onchip_ram_enable);
  pdc_cpu_model pdc_cpu_model_inst(.i_sys_clk, .i_go(go), .i_cpu_clk_en(o_cpu_clk_en),
    .o_sleep_req(i_sleep_req));
  initial
  begin
    i_sys_clk = 0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task chk(input logic [33:0] a, e);
    compares++;
    if (a !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [31:0] a, d, input logic [1:0] r = 2'b00);
    bq.push_back(r);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid <= 1;
    i_s_axi_bready <= 1;
    do
    begin
      @(posedge i_sys_clk);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 0;
  endtask
  task rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready <= 1;
    do
    begin
      @(posedge i_sys_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 0;
  endtask
  task slp;
    go <= 1;
    @(posedge i_sys_clk);
    go <= 0;
    repeat (3) @(posedge i_sys_clk);
  endtask
  task wt;
    for (int i = 0; i < 300 && o_cpu_clk_en !== 1; i++) @(posedge i_sys_clk);
    chk(o_cpu_clk_en, 1);
  endtask
  // Settle length is counted here, independent of the design's own counter
  always @(posedge i_sys_clk)
  begin
    if (o_s_axi_rvalid && i_s_axi_rready)
      chk({o_s_axi_rresp, o_s_axi_rdata}, rq.pop_front());
    if (o_s_axi_bvalid && i_s_axi_bready)
      chk(34'(o_s_axi_bresp), 34'(bq.pop_front()));
    if (o_periph_reset && o_osc_en && !o_cpu_reset) cnt++;
    if (o_wake_irq)
    begin
      chk(34'(cnt), 34'(wq.pop_front()));
      cnt = 0;
    end
  end
  initial
  begin
    #200000;
    n_errors++;
    results;
  end
  // ****************************************
  // Stimulus
  // ****************************************
  initial
  begin
    {i_reset_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 0;
    {i_s_axi_rready, i_cpu_imask, i_periph_irq, go} = 0;
    {i_res_pin_n, i_hard_standby_pin_n, i_nmi_pin_n, i_irq_pin_n} = 6'h3f;
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr} = 0;
    i_s_axi_wstrb = 4'hf;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1;
    @(posedge i_sys_clk);
    rd(SPC, 34'h09);
    @(posedge i_sys_clk);
    rd(32'h00000100, {2'b10, 32'h0});
    for (int k = 0; k < 4; k++)
    begin
      v = $random(seed);
      wr(SPC, v);
      chk({o_nmi_edge, o_dual_port_mem_enable, o_onchip_ram_enable}, v[2:0]);
      rd(SPC, {26'h0, v[7:0] | 8'h08});
    end
    // Unmapped write is refused, status reads zero, byte 0 strobe off leaves the register
    wr(32'h00000100, 32'h0, 2'b10);
    rd(`PDC_STAT_OFFSET, 34'h0);
    i_s_axi_wstrb <= 4'he;
    wr(SPC, 32'h0);
    i_s_axi_wstrb <= 4'hf;
    rd(SPC, {26'h0, v[7:0] | 8'h08});
    $display("registers done");
    wr(SPC, 32'h0);
    slp;
    chk({o_cpu_clk_en, o_periph_clk_en, o_osc_en}, 3'b011);
    wq.push_back(0);
    i_periph_irq <= 1;
    wt;
    i_periph_irq <= 0;
    i_cpu_imask <= 1;
    slp;
    i_periph_irq <= 1;
    repeat (10) @(posedge i_sys_clk);
    chk(o_cpu_clk_en, 0);
    wq.push_back(0);
    i_nmi_pin_n <= 0;
    wt;
    {i_periph_irq, i_cpu_imask, i_nmi_pin_n} <= 3'b001;
    $display("sleep done");
    for (int c = 0; c < 8; c++)
    begin
      wr(SPC, 32'h80 | (c << 4));
      slp;
      i_periph_irq <= 1;
      repeat (5) @(posedge i_sys_clk);
      chk(o_osc_en, 0);
      wq.push_back(4 << (c > 3 ? 4 : c));
      i_irq_pin_n[c % 3] <= 0;
      wt;
      {i_periph_irq, i_irq_pin_n} <= 4'h7;
      rd(SPC, 34'h88 | (c << 4));
    end
    $display("standby done");
    i_nmi_pin_n <= 0;
    wr(SPC, 32'h84);
    chk(o_nmi_edge, 1);
    slp;
    wq.push_back(4);
    i_nmi_pin_n <= 1;
    wt;
    slp;
    i_res_pin_n <= 0;
    repeat (20) @(posedge i_sys_clk);
    chk(o_cpu_reset, 1);
    i_res_pin_n <= 1;
    wt;
    rd(SPC, 34'h09);
    {i_hard_standby_pin_n, i_res_pin_n} <= 2'b00;
    repeat (5) @(posedge i_sys_clk);
    chk(o_hard_standby, 1);
    i_hard_standby_pin_n <= 1;
    repeat (10) @(posedge i_sys_clk);
    chk({o_osc_en, o_cpu_clk_en}, 2'b10);
    i_res_pin_n <= 1;
    wt;
    rd(SPC, 34'h09);
    @(posedge i_sys_clk);
    chk(34'(wq.size() + rq.size() + bq.size()), 0);
    $display("pins done");
    results;
  end
endmodule // pdc_power_down_controller_tb
`default_nettype wire
